// ---- rtl/srap_pkg.sv ----
// Purpose: shared constants and types for the SPI register access port
// Assumes: 16-bit frames, 7-bit address, 8-bit data
// Notes:   event flag registers occupy a contiguous address range
package srap_pkg;
  localparam int         FRAME_BITS   = 16;
  localparam int         ADDR_BITS    = 7;
  localparam int         DATA_BITS    = 8;
  localparam int         ADDR_MSB_POS = 15;
  localparam int         ADDR_LSB_POS = 9;
  localparam int         RW_POS       = 8;
  localparam logic       RW_READ      = 1'b1;
  localparam logic [6:0] FLAG_FIRST   = 7'h11;
  localparam logic [6:0] FLAG_LAST    = 7'h14;
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [3:0] CNT_CMD_LAST = 4'h7;
  localparam logic [3:0] CNT_FRM_LAST = 4'hF;

  typedef enum logic [2:0] {
    SRAP_IDLE = 3'b001,
    SRAP_CMD  = 3'b010,
    SRAP_DATA = 3'b100
  } srap_state_e;

  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
  } srap_cmd_s;

  typedef struct packed {
    logic       wr;
    logic       rd_done;
    logic [6:0] addr;
    logic [7:0] data;
  } srap_req_s;
endpackage : srap_pkg

// ---- rtl/srap_port.sv ----
// Purpose: SPI slave command decoder with a local 128-byte register space
// Assumes: sclk, csn, sdi synchronous to clk_sys; SPI mode 0
// Notes:   event flags set by ev_set, cleared by a completed read
//
// Behaviour
// - Frame is 16 bits; bits 15..9 carry address, MSB first.
// - Bit 8 chooses direction: one reads, zero writes.
// - Write stores data bits 7..0 into the addressed register.
// - During a read, input bits 7..0 are ignored.
// - Read leaves output undriven eight bits, then sends data MSB first.
// - Write frame never drives the output line.
// - Completed read of a flag register clears its sticky events.
`timescale 1ns/1ps
module srap_port
  import srap_pkg::*;
#(
  parameter int NREG = 128
) (
  input  wire logic       clk_sys,  // System clock
  input  wire logic       rstn,     // Sync reset, low active
  input  wire logic       sclk,     // SPI clock from host
  input  wire logic       cs_n,     // Chip select, low active
  input  wire logic       sdi,      // Serial data in
  output logic            sdo_o,    // Serial data out
  output logic            sdo_oe_n, // Output enable, low drives
  input  wire logic [7:0] ev_set,   // Event pulses per flag bit
  input  wire logic [1:0] ev_reg,   // Flag register hit by ev_set
  output logic            wr_stb,   // Write stored pulse
  output logic [6:0]      wr_addr   // Address of last write
);

  if (NREG != (1 << ADDR_BITS)) begin : g_nreg_chk
    $error("NREG must equal address space");
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on sampled SPI pins
  logic        sclk_r;
  logic        cs_n_r;
  srap_state_e st_r;
  logic [3:0]  cnt_r;
  logic [7:0]  shin_r;
  logic [7:0]  shout_r;
  srap_cmd_s   cmd_r;
  logic [7:0]  mem_r [NREG];

  wire sclk_rise = sclk & ~sclk_r;
  wire sclk_fall = ~sclk & sclk_r;
  wire cs_act    = ~cs_n;
  wire cs_start  = cs_act & cs_n_r;

  function automatic logic is_flag(input logic [6:0] a);
    return (a >= FLAG_FIRST) && (a <= FLAG_LAST);
  endfunction : is_flag

  ////////////////////////////////////////////////////////////////////////
  // Frame decode
  wire       last_bit  = sclk_rise & (cnt_r == CNT_FRM_LAST);
  wire       cmd_done  = sclk_rise & (cnt_r == CNT_CMD_LAST);
  wire [7:0] shin_nxt  = {shin_r[6:0], sdi};
  srap_req_s req;
  assign req.wr      = last_bit & ~cmd_r.rd & (st_r == SRAP_DATA);
  assign req.rd_done = last_bit & cmd_r.rd & (st_r == SRAP_DATA);
  assign req.addr    = cmd_r.addr;
  assign req.data    = shin_nxt;
  wire [6:0] ev_addr = FLAG_FIRST + {5'h00, ev_reg};
  wire       ev_hit  = (req.addr == ev_addr);
  wire [7:0] ev_base = (req.rd_done && ev_hit) ? 8'h00
                     : ((req.wr && ev_hit) ? req.data : mem_r[ev_addr]);
  wire [6:0] fetch_addr = (st_r == SRAP_CMD) ? shin_r[6:0] : cmd_r.addr;

  ////////////////////////////////////////////////////////////////////////
  // Frame state machine
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      st_r   <= SRAP_IDLE;
      cnt_r  <= 4'h0;
      shin_r <= 8'h00;
      cmd_r  <= '0;
    end else begin
      sclk_r <= sclk;
      cs_n_r <= cs_n;
      if (!cs_act) begin
        st_r  <= SRAP_IDLE;
        cnt_r <= 4'h0;
      end else begin
        if (cs_start)
          st_r <= SRAP_CMD;
        if (sclk_rise && st_r != SRAP_IDLE) begin
          shin_r <= shin_nxt;
          cnt_r  <= cnt_r + 4'h1;
        end
        if (cmd_done && st_r == SRAP_CMD) begin
          cmd_r.addr <= shin_r[6:0];
          cmd_r.rd   <= (sdi == RW_READ);
          st_r       <= SRAP_DATA;
        end
        if (last_bit)
          st_r <= SRAP_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register space and sticky flags
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < NREG; i++)
        mem_r[i] <= REG_RST;
    end else begin
      if (req.wr)
        mem_r[req.addr] <= req.data;
      if (req.rd_done && is_flag(req.addr))
        mem_r[req.addr] <= 8'h00;
      if (|ev_set)
        mem_r[ev_addr] <= ev_base | ev_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output path, changes on falling edge for mode 0
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sdo_o    <= 1'b0;
      sdo_oe_n <= 1'b1;
      shout_r  <= 8'h00;
      wr_stb   <= 1'b0;
      wr_addr  <= 7'h00;
    end else begin
      wr_stb <= req.wr;
      if (req.wr)
        wr_addr <= req.addr;
      if (!cs_act || st_r != SRAP_DATA || !cmd_r.rd) begin
        sdo_oe_n <= 1'b1;
        shout_r  <= mem_r[fetch_addr];
      end else if (sclk_fall) begin
        sdo_oe_n <= 1'b0;
        sdo_o    <= shout_r[7];
        shout_r  <= {shout_r[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_wr_end;
    req.wr;
  endsequence
  sequence s_rd_cmd;
    cmd_done && st_r == SRAP_CMD && sdi == RW_READ;
  endsequence
  sequence s_rd_shift;
    st_r == SRAP_DATA && cmd_r.rd && cs_act && sclk_fall;
  endsequence

  AST_WR_NO_DRIVE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_r == SRAP_DATA && !cmd_r.rd) |-> sdo_oe_n)
    else $error("output driven in write frame");
  AST_CMD_NO_DRIVE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_r == SRAP_CMD) |=> sdo_oe_n)
    else $error("output driven during command bits");
  AST_IDLE_NO_DRIVE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !cs_act |=> sdo_oe_n)
    else $error("output driven without select");
  AST_WR_STORE: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_wr_end |=> (mem_r[$past(req.addr)] == $past(req.data)
                  || is_flag($past(req.addr))))
    else $error("write data not stored");
  AST_WR_STB: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_wr_end |=> wr_stb && wr_addr == $past(cmd_r.addr))
    else $error("write strobe missing");
  AST_RD_NO_STORE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rd_done && !is_flag(req.addr) && !(|ev_set)) |=>
    $stable(mem_r[$past(req.addr)]))
    else $error("read changed register");
  AST_FLAG_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rd_done && is_flag(req.addr) && !(|ev_set)) |=>
    mem_r[$past(req.addr)] == 8'h00)
    else $error("flag register not cleared");
  AST_ABORT: assert property (@(posedge clk_sys) disable iff (!rstn)
    !cs_act |=> st_r == SRAP_IDLE && cnt_r == 4'h0)
    else $error("frame not aborted");
  AST_DIR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cmd_done && st_r == SRAP_CMD && cs_act) |=> cmd_r.rd == $past(sdi))
    else $error("direction bit misdecoded");
  AST_ADDR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cmd_done && st_r == SRAP_CMD && cs_act) |=>
    cmd_r.addr == $past(shin_r[6:0]))
    else $error("address misdecoded");
  AST_RD_FETCH: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_rd_cmd |=> shout_r == $past(mem_r[shin_r[6:0]]))
    else $error("read data not fetched from new address");
  AST_RD_SHIFT: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_rd_shift |=> !sdo_oe_n && sdo_o == $past(shout_r[7]))
    else $error("read bit not shifted out");
  AST_RD_OE_LOW: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_r == SRAP_DATA && cmd_r.rd && cs_act && !sdo_oe_n) |=> !sdo_oe_n)
    else $error("read output released mid data");
  AST_EV_WINS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (|ev_set) |=> ((mem_r[$past(ev_addr)] & $past(ev_set))
                   == $past(ev_set)))
    else $error("event lost against clear or write");
  AST_STB_ONE: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_stb |=> !wr_stb)
    else $error("write strobe longer than one cycle");
  AST_OE_RELEASE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_r == SRAP_IDLE) |=> sdo_oe_n)
    else $error("output driven outside frame");
  AST_EXTRA_IGNORED: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_r == SRAP_IDLE && cs_act && !cs_start) |=>
    st_r == SRAP_IDLE)
    else $error("bits after frame end not ignored");
  AST_FRAME_END: assert property (@(posedge clk_sys) disable iff (!rstn)
    last_bit |=> st_r == SRAP_IDLE)
    else $error("frame did not end after sixteen bits");
  AST_FRAME_START: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_start |=> st_r == SRAP_CMD && cnt_r == 4'h0)
    else $error("frame start not taken");

endmodule : srap_port

// ---- tb/spi_register_access_port_test.sv ----
// Purpose: self-checking bench for the SPI register access port
// Assumes: host model drives all frames
// Notes:   stimulus moves 1 ns after clk_sys rises
`timescale 1ns/1ps
module spi_register_access_port_test;
  import srap_pkg::*;
  logic clk_sys, rstn, sclk, cs_n, sdi, sdo_o, sdo_oe_n, wr_stb;
  logic [7:0] ev_set;
  logic [1:0] ev_reg;
  logic [6:0] wr_addr;
  logic [15:0] rx, oe;
  int num_errors, tests_run, stb_cnt;
  srap_port dut (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
    .ev_set(ev_set), .ev_reg(ev_reg), .wr_stb(wr_stb),
    .wr_addr(wr_addr));
  srap_host host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (wr_stb === 1'b1) stb_cnt++;
  task check(input string what, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task finish_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(16, {a, 1'b0, d}, rx, oe);
    check("write oe", oe, 16'hFFFF);
    check("wr_addr", {9'h000, wr_addr}, {9'h000, a});
  endtask : wr
  task rd(input logic [6:0] a, input logic [7:0] d, input logic [7:0] j);
    host.xfer(16, {a, 1'b1, j}, rx, oe);
    check("read oe", oe, 16'hFF00);
    check("read data", {8'h00, rx[7:0]}, {8'h00, d});
  endtask : rd
  task t_write_read;
    rd(7'h05, 8'h00, 8'h00);
    wr(7'h7F, 8'hA5);
    wr(7'h00, 8'h5A);
    check("stb count", stb_cnt[15:0], 16'h0002);
    rd(7'h7F, 8'hA5, 8'hFF);
    rd(7'h00, 8'h5A, 8'h00);
    rd(7'h7F, 8'hA5, 8'h00);
  endtask : t_write_read
  task t_flags;
    @(posedge clk_sys);
    #1 ev_reg = 2'h2;
    ev_set = 8'h81;
    @(posedge clk_sys);
    #1 ev_reg = 2'h0;
    ev_set = 8'h24;
    @(posedge clk_sys);
    #1 ev_set = 8'h00;
    rd(7'h13, 8'h81, 8'h00);
    rd(7'h13, 8'h00, 8'h00);
    rd(7'h11, 8'h24, 8'h00);
  endtask : t_flags
  task t_abort;
    host.xfer(12, {7'h7F, 1'b0, 8'h3C}, rx, oe);
    check("abort stb", stb_cnt[15:0], 16'h0002);
    rd(7'h7F, 8'hA5, 8'h00);
  endtask : t_abort
  initial begin
    #100000 num_errors++;
    finish_test();
  end
  initial begin
    rstn = 1'b0;
    ev_set = 8'h00;
    ev_reg = 2'h0;
    num_errors = 0;
    tests_run = 0;
    stb_cnt = 0;
    repeat (12) @(posedge clk_sys);
    #1 rstn = 1'b1;
    t_write_read();
    t_flags();
    t_abort();
    finish_test();
  end
endmodule : spi_register_access_port_test

// ---- tb/srap_host.sv ----
// Purpose: SPI host model issuing command frames
// Assumes: mode 0, each sclk phase lasts 4 clk_sys cycles
// Notes:   released sdo reads back as inverse of last bit
`timescale 1ns/1ps
module srap_host (
  input  wire logic clk_sys,  // System clock
  output logic      sclk,     // SPI clock
  output logic      cs_n,     // Chip select
  output logic      sdi,      // Data to device
  input  wire logic sdo_o,    // Device data
  input  wire logic sdo_oe_n  // Device enable, low drives
);
  logic last;
  logic line;
  assign line = sdo_oe_n ? ~last : sdo_o;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
    last = 1'b0;
  end
  // Sends n bits of tx, sampling line and enable at each rise
  task xfer(input int n, input logic [15:0] tx,
            output logic [15:0] rx, output logic [15:0] oe);
    rx = 16'h0000;
    oe = 16'h0000;
    repeat (3) @(posedge clk_sys);
    #1 cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      sdi = tx[i];
      repeat (4) @(posedge clk_sys);
      #1 sclk = 1'b1;
      rx[i] = line;
      oe[i] = sdo_oe_n;
      last = line;
      repeat (4) @(posedge clk_sys);
      #1 sclk = 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    #1 cs_n = 1'b1;
    sdi = ~sdi;
  endtask : xfer
endmodule : srap_host
